// [shared/pes_pkg.sv]
/*
  Constants, carrier types and the address decode for the program
  array sequencer. Assumes a 200 MHz bus clock and an APB master.
*/
package pes_pkg;
  localparam logic [15:0] CTRL_OFF = 16'h0000;
  localparam logic [15:0] STAT_OFF = 16'h0004;
  localparam logic [15:0] ARR_BASE = 16'h2000;
  localparam logic [15:0] ARR_LAST = 16'h3EFF;
  localparam logic [15:0] VEC_BASE = 16'h3FF0;
  localparam logic [15:0] VEC_LAST = 16'h3FFF;
  localparam int ARR_BYTES = 7936;
  localparam int VEC_BYTES = 16;
  localparam int NUM_GRPS  = (ARR_BYTES + VEC_BYTES) / 4;
  localparam int IDX_W     = 11;
  localparam logic [IDX_W-1:0] OPT_IDX = 11'h000;
  localparam logic [IDX_W-1:0] VEC_IDX = 11'(ARR_BYTES / 4);
  // status word fields
  localparam int ST_DONE = 0;
  localparam int ST_REJ  = 1;
  localparam int ST_SEEN = 2;
  localparam int ST_PROT = 3;
  localparam int ST_TIME = 4;
  localparam int ST_OPT  = 8;
  localparam logic [4:0]  CTRL_RST   = 5'h03;
  localparam logic [7:0]  ERASED     = 8'h00;
  localparam logic [31:0] BUSY_READ  = 32'hFFFFFFFF;
  // timing
  localparam int CLK_MHZ     = 200;
  localparam int PROG_MIN_MS = 5;
  localparam int BULK_MIN_MS = 400;
  localparam int PROG_CYC    = PROG_MIN_MS * CLK_MHZ * 1000;
  localparam int BULK_CYC    = BULK_MIN_MS * CLK_MHZ * 1000;
  localparam int CNT_W       = 27;

  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [15:0] paddr;
    logic [31:0] pwdata;
    logic [3:0]  pstrb;
  } pes_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } pes_apb_rsp_t;

  typedef struct packed {
    logic osc_on;
    logic bulk_select;
    logic write_erase_select;
    logic latch_enable;
    logic program_enable_low;
  } pes_ctrl_t;

  typedef struct packed {
    logic spare7;
    logic over_volt_reset_enable;
    logic over_temp_reset_enable;
    logic stop_reset;
    logic spare3;
    logic clock_monitor_enable;
    logic array_protect;
    logic watchdog_disable;
  } pes_opt_t;

  typedef struct packed {
    logic             we;
    logic             clear_all;
    logic [IDX_W-1:0] idx;
    logic [3:0]       mask;
    logic [31:0]      data;
  } pes_mem_wr_t;

  // word address to group index; top bit flags a hit
  function automatic logic [IDX_W:0] pes_grp(input logic [15:0] a);
    logic [15:0] o;
    o = '0;
    if (a >= ARR_BASE && a <= ARR_LAST) begin
      o = a - ARR_BASE;
      return {1'b1, o[IDX_W+1:2]};
    end
    if (a >= VEC_BASE && a <= VEC_LAST) begin
      o = a - VEC_BASE;
      return {1'b1, VEC_IDX + {9'h000, o[3:2]}};
    end
    return '0;
  endfunction
endpackage

// [rtl/pes_array.sv]
/*
  Storage for the program array, one 32-bit word per four-byte group.
  Assumes blank_n_in is only pulsed to model a factory-blank part.
*/
`timescale 1ns/1ps
module pes_array
  import pes_pkg::*;
(
  input  wire logic             sys_clk_in,
  input  wire logic             blank_n_in,
  input  pes_mem_wr_t           wr_in,
  input  wire logic [IDX_W-1:0] rd_idx_in,
  output logic [31:0]           rd_data_out
);
  logic [31:0]         mem [NUM_GRPS];
  logic [NUM_GRPS-1:0] valid_reg;
  logic [31:0]         base;

  // a word never written reads erased, so no init file is needed
  assign base = valid_reg[wr_in.idx] ? mem[wr_in.idx] : '0;

  // byte-lane write; registered read
  always_ff @(posedge sys_clk_in) begin
    if (wr_in.we) begin
      for (int l = 0; l < 4; l++) begin
        mem[wr_in.idx][8*l +: 8] <= wr_in.mask[l] ?
          wr_in.data[8*l +: 8] : base[8*l +: 8];
      end
    end
    if (int'(rd_idx_in) < NUM_GRPS && valid_reg[rd_idx_in]) begin
      rd_data_out <= mem[rd_idx_in];
    end else begin
      rd_data_out <= '0;
    end
  end

  // clear valid bits stand for erased contents; bulk erase drops them all
  always_ff @(posedge sys_clk_in or negedge blank_n_in) begin
    if (!blank_n_in) begin
      valid_reg <= '0;
    end else if (wr_in.clear_all) begin
      valid_reg <= '0;
    end else if (wr_in.we) begin
      valid_reg[wr_in.idx] <= 1'b1;
    end
  end
endmodule // pes_array

// [rtl/pes_top.sv]
/*
  Program array sequencer: APB registers, group latches, pump timing,
  protection and option latches. Assumes APB synchronous to sys_clk_in
  and rst_n_in being the power-on or external reset.
*/
`timescale 1ns/1ps
module pes_top
  import pes_pkg::*;
#(
  parameter int PROG_CYCLES = PROG_CYC,
  parameter int BULK_CYCLES = BULK_CYC
) (
  input  wire logic   sys_clk_in,
  input  wire logic   rst_n_in,
  input  wire logic   mem_blank_n_in,
  input  pes_apb_req_t apb_in,
  output pes_apb_rsp_t apb_out,
  input  wire logic   bootloader_mode_in,
  input  wire logic   stop_entry_in,
  input  wire logic   stop_exec_in,
  input  wire logic   osc_fail_in,
  input  wire logic   over_temp_in,
  input  wire logic   over_volt_in,
  output logic        osc_on_out,
  output logic        rc_select_out,
  output logic        mcu_reset_out,
  output logic        watchdog_enable_out,
  output logic        over_temp_reset_out,
  output logic        over_volt_reset_out,
  output logic        stop_reset_out,
  output logic        pump_on_out
);
  typedef enum logic [1:0] {PH_LOAD, PH_CAPT, PH_RUN} pes_phase_t;

  typedef struct packed {
    pes_phase_t       phase;
    pes_ctrl_t        ctrl;
    pes_opt_t         opt;
    logic             protect;
    logic [IDX_W-1:0] grp_idx;
    logic [31:0]      grp_data;
    logic [3:0]       lane_mask;
    logic             mode_write;
    logic             store_seen;
    logic [CNT_W-1:0] cnt;
    logic             acc;
    pes_apb_rsp_t     rsp;
    logic             flag_done;
    logic             flag_rej;
    logic             mcu_reset;
    logic             rc_select;
    logic             wd_en;
    logic             ot_rst;
    logic             ov_rst;
    logic             stop_rst;
    logic             pump_on;
  } pes_state_t;

  pes_state_t       s_reg;
  pes_state_t       s_next;
  pes_mem_wr_t      wr;
  logic [IDX_W-1:0] rd_idx;
  logic [31:0]      rd_data;

  pes_array u_array (
    .sys_clk_in  (sys_clk_in),
    .blank_n_in  (mem_blank_n_in),
    .wr_in       (wr),
    .rd_idx_in   (rd_idx),
    .rd_data_out (rd_data)
  );

  // next state of the whole block
  always_comb begin
    logic [IDX_W:0]   hit;
    logic             acc_ph;
    logic             done_ph;
    logic             ok;
    logic             bulk_er;
    logic [CNT_W-1:0] tmin;
    pes_ctrl_t        d;
    logic [31:0]      stat;
    hit     = pes_grp(apb_in.paddr);
    acc_ph  = apb_in.psel && apb_in.penable;
    done_ph = acc_ph && s_reg.rsp.pready;
    d       = apb_in.pwdata[4:0];
    bulk_er = s_reg.ctrl.bulk_select && !s_reg.mode_write;
    tmin    = bulk_er ? CNT_W'(BULK_CYCLES) : CNT_W'(PROG_CYCLES);
    ok      = 1'b0;
    stat    = '0;
    stat[ST_DONE] = s_reg.flag_done;
    stat[ST_REJ]  = s_reg.flag_rej;
    stat[ST_SEEN] = s_reg.store_seen;
    stat[ST_PROT] = s_reg.protect;
    stat[ST_TIME] = s_reg.cnt >= tmin;
    stat[ST_OPT +: 8] = s_reg.opt;
    s_next = s_reg;
    wr     = '0;
    rd_idx = (s_reg.phase == PH_RUN) ? hit[IDX_W-1:0] : OPT_IDX;

    // option word is fetched once after every reset release
    case (s_reg.phase)
      PH_LOAD: s_next.phase = PH_CAPT;
      PH_CAPT: begin
        s_next.opt     = rd_data[7:0];
        s_next.protect = rd_data[1];
        s_next.phase   = PH_RUN;
      end
      PH_RUN: ;
      default: s_next.phase = PH_LOAD;
    endcase

    // pump time counts while enabled; wait mode does not stop it
    if (!s_reg.ctrl.latch_enable && !s_reg.ctrl.program_enable_low) begin
      if (s_reg.cnt != {CNT_W{1'b1}}) begin
        s_next.cnt = s_reg.cnt + 1'b1;
      end
    end else begin
      s_next.cnt = '0;
    end

    // apb: two wait cycles, then pready for one cycle
    s_next.rsp.pready = 1'b0;
    if (acc_ph && !s_reg.rsp.pready && s_reg.phase == PH_RUN) begin
      if (!s_reg.acc) begin
        s_next.acc = 1'b1;
      end else begin
        s_next.acc         = 1'b0;
        s_next.rsp.pready  = 1'b1;
        s_next.rsp.pslverr = 1'b0;
        if (apb_in.paddr == CTRL_OFF) begin
          s_next.rsp.prdata = {27'h0000000, s_reg.ctrl};
        end else if (apb_in.paddr == STAT_OFF) begin
          s_next.rsp.prdata = stat;
        end else if (hit[IDX_W]) begin
          // latched group hides the array while the pump may run
          s_next.rsp.prdata = s_reg.ctrl.latch_enable ?
            rd_data : BUSY_READ;
        end else begin
          s_next.rsp.prdata  = '0;
          s_next.rsp.pslverr = 1'b1;
        end
      end
    end

    // write effects land on the completing edge only
    if (done_ph && apb_in.pwrite && apb_in.paddr == CTRL_OFF) begin
      s_next.ctrl.osc_on             = d.osc_on;
      s_next.ctrl.bulk_select        = d.bulk_select;
      s_next.ctrl.write_erase_select = d.write_erase_select;
      s_next.ctrl.latch_enable       = d.latch_enable;
      if (d.latch_enable) begin
        s_next.ctrl.program_enable_low = 1'b1;
        s_next.store_seen = 1'b0;
        s_next.lane_mask  = '0;
        if (!s_reg.ctrl.latch_enable && !s_reg.ctrl.program_enable_low) begin
          // ending a pulse commits the group if it was legal and long enough
          ok = s_reg.store_seen && s_reg.cnt >= tmin;
          if (!bootloader_mode_in) begin
            ok = ok && !s_reg.protect;
            ok = ok && s_reg.grp_idx != OPT_IDX;
            ok = ok && !bulk_er;
          end
          ok = ok && !(s_reg.mode_write && s_reg.ctrl.bulk_select);
          s_next.flag_done = ok;
          s_next.flag_rej  = !ok;
        end
      end else if (!d.program_enable_low) begin
        if (!s_reg.ctrl.latch_enable && s_reg.store_seen) begin
          s_next.ctrl.program_enable_low = 1'b0;
        end
      end else begin
        s_next.ctrl.program_enable_low = 1'b1;
      end
    end else if (done_ph && apb_in.pwrite && apb_in.paddr == STAT_OFF) begin
      // write one to clear
      if (apb_in.pwdata[ST_DONE]) s_next.flag_done = 1'b0;
      if (apb_in.pwdata[ST_REJ]) s_next.flag_rej = 1'b0;
    end else if (done_ph && apb_in.pwrite && hit[IDX_W]) begin
      // stores only reach the latches while enable-low is still high
      if (!s_reg.ctrl.latch_enable && s_reg.ctrl.program_enable_low) begin
        if (!s_reg.store_seen) begin
          s_next.grp_idx    = hit[IDX_W-1:0];
          s_next.mode_write = s_reg.ctrl.write_erase_select;
          s_next.store_seen = 1'b1;
          s_next.lane_mask  = apb_in.pstrb;
        end else begin
          s_next.lane_mask = s_reg.lane_mask | apb_in.pstrb;
        end
        for (int l = 0; l < 4; l++) begin
          if (apb_in.pstrb[l]) begin
            s_next.grp_data[8*l +: 8] = apb_in.pwdata[8*l +: 8];
          end
        end
      end
    end

    // entering stop drops back to read state and cancels the group
    if (stop_entry_in) begin
      s_next.ctrl.latch_enable       = 1'b1;
      s_next.ctrl.program_enable_low = 1'b1;
      s_next.store_seen = 1'b0;
      s_next.lane_mask  = '0;
      s_next.flag_done  = s_reg.flag_done;
      s_next.flag_rej   = s_reg.flag_rej;
      ok = 1'b0;
    end

    // array write port; bulk erase clears every group at once
    wr.we        = ok && !bulk_er;
    wr.clear_all = ok && bulk_er;
    wr.idx       = s_reg.grp_idx;
    wr.mask      = s_reg.lane_mask;
    wr.data      = s_reg.mode_write ? s_reg.grp_data : {4{ERASED}};

    // programming protect in the option word takes hold at once
    if (wr.we && wr.idx == OPT_IDX && wr.mask[0] && wr.data[1]) begin
      s_next.protect = 1'b1;
    end
    if (wr.clear_all) begin
      s_next.protect = s_reg.protect;
    end

    // option functions run from the latched copy only
    if (s_reg.phase == PH_RUN) begin
      s_next.wd_en     = !s_reg.opt.watchdog_disable;
      s_next.ot_rst    = s_reg.opt.over_temp_reset_enable && over_temp_in;
      s_next.ov_rst    = s_reg.opt.over_volt_reset_enable && over_volt_in;
      s_next.stop_rst  = s_reg.opt.stop_reset && stop_exec_in;
      s_next.mcu_reset = s_reg.opt.clock_monitor_enable && osc_fail_in;
      if (s_next.mcu_reset) begin
        s_next.rc_select = 1'b1;
      end
    end
    s_next.pump_on = !s_next.ctrl.latch_enable;
  end

  // single state register; protect stays set until reset
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      s_reg      <= '0;
      s_reg.ctrl <= CTRL_RST;
      s_reg.phase <= PH_LOAD;
      s_reg.protect <= 1'b1;
    end else begin
      s_reg <= s_next;
    end
  end

  assign apb_out             = s_reg.rsp;
  assign osc_on_out          = s_reg.ctrl.osc_on;
  assign rc_select_out       = s_reg.rc_select;
  assign mcu_reset_out       = s_reg.mcu_reset;
  assign watchdog_enable_out = s_reg.wd_en;
  assign over_temp_reset_out = s_reg.ot_rst;
  assign over_volt_reset_out = s_reg.ov_rst;
  assign stop_reset_out      = s_reg.stop_rst;
  assign pump_on_out         = s_reg.pump_on;

  // checks
  AST_LATCH_FORCES_PGM: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.ctrl.latch_enable |-> s_reg.ctrl.program_enable_low)
    else $error("enable-low clear while latch set");
  AST_PGM_CLEAR_GUARD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $fell(s_reg.ctrl.program_enable_low) |->
      !$past(s_reg.ctrl.latch_enable) && $past(s_reg.store_seen))
    else $error("enable-low cleared without latch and store");
  AST_STOP_READ: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    stop_entry_in |=> s_reg.ctrl.latch_enable && !s_reg.store_seen ##1 pump_on_out == 1'b0)
    else $error("stop did not return array to read");
  AST_OPT_WORD_LOCKED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.we && !bootloader_mode_in |-> wr.idx != OPT_IDX)
    else $error("option group written in single chip");
  AST_PROTECT_READONLY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.protect && !bootloader_mode_in |-> !wr.we && !wr.clear_all)
    else $error("protected array changed");
  AST_PROTECT_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN && s_reg.protect |=> s_reg.protect)
    else $error("protection dropped before reset");
  AST_NO_BULK_SINGLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    !bootloader_mode_in |-> !wr.clear_all)
    else $error("bulk erase in single chip");
  AST_ADDR_HELD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.store_seen && $past(s_reg.store_seen) |-> $stable(s_reg.grp_idx))
    else $error("group address moved");
  AST_OPT_STABLE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN |=> $stable(s_reg.opt) ##1 watchdog_enable_out == !s_reg.opt[0])
    else $error("option latches changed while running");
  AST_CLK_MON: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN && s_reg.opt.clock_monitor_enable && osc_fail_in
      |=> mcu_reset_out && rc_select_out)
    else $error("clock monitor did not reset");
  AST_STOP_RESET: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN && stop_exec_in |=> stop_reset_out == $past(s_reg.opt.stop_reset))
    else $error("stop reset option ignored");
  AST_APB_ANSWER: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN && apb_in.psel && apb_in.penable && !apb_out.pready
      && !s_reg.acc |=> ##1 apb_out.pready)
    else $error("apb answer late");

  // handshake and array write checks
  AST_APB_PULSE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    apb_out.pready |=> !apb_out.pready)
    else $error("pready held longer than one cycle");
  AST_APB_STALL_LOAD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase != PH_RUN |=> !apb_out.pready)
    else $error("apb answered before options loaded");
  AST_PUMP_LATCH: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    pump_on_out == !s_reg.ctrl.latch_enable)
    else $error("pump state differs from latch bit");
  AST_STORE_LATCHED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    $rose(s_reg.store_seen) |-> s_reg.ctrl.program_enable_low && !s_reg.ctrl.latch_enable)
    else $error("store captured outside latch window");
  AST_MODE_HELD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.store_seen && $past(s_reg.store_seen) |-> $stable(s_reg.mode_write))
    else $error("write/erase mode changed inside a group");
  AST_COMMIT_NEEDS_STORE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.we || wr.clear_all |-> s_reg.store_seen && !s_reg.ctrl.program_enable_low)
    else $error("commit without store or enable");
  AST_WRITE_TIMED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.we |-> s_reg.cnt >= CNT_W'(PROG_CYCLES))
    else $error("group written before pulse time");
  AST_BULK_TIMED: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    wr.clear_all |-> s_reg.cnt >= CNT_W'(BULK_CYCLES) && !s_reg.mode_write)
    else $error("bulk erase too short or in write mode");
  AST_STOP_CANCEL: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    stop_entry_in |-> !wr.we && !wr.clear_all)
    else $error("commit allowed on stop entry");

  // option latch checks
  AST_OPT_CAPTURE: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_CAPT |=> s_reg.opt == $past(rd_data[7:0]))
    else $error("option byte not copied at reset");
  AST_PROTECT_LOAD: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_CAPT |=> s_reg.protect == $past(rd_data[1]))
    else $error("protect latch not loaded at reset");
  AST_WD_OUT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN |=> watchdog_enable_out == !$past(s_reg.opt.watchdog_disable))
    else $error("watchdog enable differs from option");
  AST_OT_OUT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN |=>
      over_temp_reset_out == $past(s_reg.opt.over_temp_reset_enable && over_temp_in))
    else $error("over-temperature reset differs from option");
  AST_OV_OUT: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    s_reg.phase == PH_RUN |=>
      over_volt_reset_out == $past(s_reg.opt.over_volt_reset_enable && over_volt_in))
    else $error("over-voltage reset differs from option");
  AST_RC_STICKY: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in)
    rc_select_out |=> rc_select_out)
    else $error("oscillator selection dropped before reset");
endmodule // pes_top

// [test/pes_top_bench.sv]
/*
  Self-checking bench for pes_top: APB master tasks, a reference model
  of array words, protection and option latches, compared at each result.
  Assumes the short pump counts set below and stores always use all lanes.
*/
`timescale 1ns/1ps
module pes_top_bench;
  import pes_pkg::*;
  localparam int PC = 8;
  localparam int BC = 16;
  logic         sys_clk, rst_n, boot, stop_in, stop_x, osc_f, hot, volt;
  logic         osc_on, rc_sel, mcu_rst, wd_en, t_rst, v_rst, s_rst, pump;
  logic         prot, err_bit, blank_n;
  logic [31:0]  rd;
  logic [31:0]  model [logic [15:0]];
  pes_apb_req_t req;
  pes_apb_rsp_t rsp;
  int           num_errors, total_checks, seed;

  pes_top #(.PROG_CYCLES(PC), .BULK_CYCLES(BC)) pes_top_inst (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .mem_blank_n_in(blank_n), .apb_in(req),
    .apb_out(rsp), .bootloader_mode_in(boot), .stop_entry_in(stop_in),
    .stop_exec_in(stop_x), .osc_fail_in(osc_f), .over_temp_in(hot), .over_volt_in(volt),
    .osc_on_out(osc_on), .rc_select_out(rc_sel), .mcu_reset_out(mcu_rst),
    .watchdog_enable_out(wd_en), .over_temp_reset_out(t_rst),
    .over_volt_reset_out(v_rst), .stop_reset_out(s_rst), .pump_on_out(pump));

  // 200 MHz bus clock
  always #2.5 sys_clk = ~sys_clk;

  task final_report;
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask

  // one APB transfer; request held until pready is sampled high
  task apb(input logic w, input logic [15:0] a, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    req <= '{psel:1'b1, penable:1'b0, pwrite:w, paddr:a, pwdata:d, pstrb:4'hF};
    @(posedge sys_clk);
    req.penable <= 1'b1;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (rsp.pready !== 1'b1 && n < 40);
    if (n >= 40) begin
      num_errors++;
      final_report();
    end
    rd = rsp.prdata;
    err_bit = rsp.pslverr;
    req.psel <= 1'b0;
    req.penable <= 1'b0;
  endtask

  // unwritten words read zero in this model
  function automatic logic [31:0] mv(input logic [15:0] k);
    return model.exists(k) ? model[k] : 32'h0;
  endfunction

  // options and protection are reloaded from the stored word
  task do_reset;
    rst_n <= 1'b0;
    repeat (16) @(posedge sys_clk);
    rst_n <= 1'b1;
    blank_n <= 1'b1; // array starts blank; later resets keep its contents
    repeat (4) @(posedge sys_clk);
    rd = mv(ARR_BASE);
    prot = rd[1];
  endtask

  task chk_opts;
    logic [7:0] o;
    o = 8'(mv(ARR_BASE));
    apb(0, STAT_OFF, 32'h0);
    chk(rd[15:8], o);
    chk(rd[3], o[1]);
    chk(wd_en, !o[0]);
    hot <= 1'b1;
    volt <= 1'b1;
    stop_x <= 1'b1;
    osc_f <= 1'b1;
    @(posedge sys_clk);
    osc_f <= 1'b0;
    @(posedge sys_clk);
    chk(mcu_rst, o[2]);
    chk(t_rst, o[5]);
    chk(v_rst, o[6]);
    chk(s_rst, o[4]);
    hot <= 1'b0;
    volt <= 1'b0;
    stop_x <= 1'b0;
    @(posedge sys_clk);
    chk(rc_sel, o[2]);
    chk(mcu_rst, 1'b0);
  endtask

  // full latch, store, pump and commit sequence with model update
  task grp(input logic [15:0] a, input logic [31:0] d, input logic wr, input logic bk,
           input logic [15:0] a2);
    logic        rej;
    logic [31:0] f, d2;
    f = {27'h0, 1'b0, bk, wr, 2'b01};
    d2 = d;
    apb(1, CTRL_OFF, f);
    apb(1, CTRL_OFF, f & 32'h1E);
    apb(0, CTRL_OFF, 32'h0);
    chk(rd[4:0], f[4:0]);
    chk(pump, 1'b1);
    apb(1, a, d);
    if (a2 != 16'h0) begin
      d2 = $random(seed);
      apb(1, a2, d2);
    end
    apb(0, a, 32'h0);
    chk(rd, BUSY_READ);
    apb(1, CTRL_OFF, f & 32'h1E);
    apb(0, CTRL_OFF, 32'h0);
    chk(rd[0], 1'b0);
    repeat (bk ? BC : PC) @(posedge sys_clk);
    apb(0, STAT_OFF, 32'h0);
    chk(rd[4:2], {1'b1, prot, 1'b1});
    apb(1, CTRL_OFF, f | 32'h2);
    apb(0, CTRL_OFF, 32'h0);
    chk(rd[1:0], 2'b11);
    chk(pump, 1'b0);
    rej = (bk && (!boot || wr)) || (!boot && (prot || a[15:2] == ARR_BASE[15:2]));
    if (!rej) begin
      if (bk) model.delete();
      else model[{a[15:2], 2'b00}] = wr ? d2 : 32'h0;
      if (wr && !bk && a[15:2] == ARR_BASE[15:2] && d2[1]) prot = 1'b1;
    end
    apb(0, STAT_OFF, 32'h0);
    chk(rd[1:0], rej ? 2'b10 : 2'b01);
    apb(0, a, 32'h0);
    chk(rd, mv({a[15:2], 2'b00}));
    if (a2 != 16'h0) begin
      apb(0, a2, 32'h0);
      chk(rd, mv(a2));
    end
  endtask

  // main sequence; options start blank so the array is writable
  initial begin
    sys_clk = 1'b0;
    rst_n = 1'b0;
    blank_n = 1'b0;
    boot = 1'b0;
    stop_in = 1'b0;
    stop_x = 1'b0;
    osc_f = 1'b0;
    hot = 1'b0;
    volt = 1'b0;
    req = '0;
    prot = 1'b0;
    seed = 32'he1b0;
    num_errors = 0;
    total_checks = 0;
    do_reset;
    apb(0, CTRL_OFF, 32'h0);
    chk(rd[4:0], CTRL_RST);
    chk(pump, 1'b0);
    apb(0, 16'h1000, 32'h0);
    chk(err_bit, 1'b1);
    apb(1, CTRL_OFF, 32'h13);
    apb(0, CTRL_OFF, 32'h0);
    chk(osc_on, 1'b1);
    apb(1, CTRL_OFF, 32'h03);
    chk_opts;
    for (int i = 0; i < 4; i++) grp(16'h2004 + 16'(i * 4), $random(seed), 1, 0, 0);
    apb(1, STAT_OFF, 32'h3);
    apb(0, STAT_OFF, 32'h0);
    chk(rd[4:0], 32'h0);
    grp(16'h3FFC, $random(seed), 1, 0, 16'h2020);
    grp(16'h2008, 32'h0, 0, 0, 0);
    grp(ARR_BASE, $random(seed), 1, 0, 0);
    grp(16'h2004, 32'h0, 0, 1, 0);
    boot <= 1'b1;
    grp(16'h2004, 32'h0, 1, 1, 0);
    grp(ARR_BASE, 32'h77, 1, 0, 0);
    chk(wd_en, 1'b1);
    boot <= 1'b0;
    grp(16'h2010, $random(seed), 1, 0, 0);
    do_reset;
    chk_opts;
    grp(16'h2010, $random(seed), 1, 0, 0);
    boot <= 1'b1;
    grp(16'h2010, $random(seed), 1, 0, 0);
    grp(ARR_BASE, 32'h0, 0, 0, 0);
    boot <= 1'b0;
    grp(16'h2014, $random(seed), 1, 0, 0);
    do_reset;
    chk_opts;
    grp(16'h2014, $random(seed), 1, 0, 0);
    boot <= 1'b1;
    grp(16'h2018, 32'h0, 0, 1, 0);
    boot <= 1'b0;
    // stop entry must drop the pump and return to read state
    apb(1, CTRL_OFF, 32'h05);
    stop_in <= 1'b1;
    @(posedge sys_clk);
    stop_in <= 1'b0;
    repeat (3) @(posedge sys_clk);
    chk(pump, 1'b0);
    apb(0, CTRL_OFF, 32'h0);
    chk(rd[1], 1'b1);
    final_report;
  end
endmodule // pes_top_bench
